// ### src/dost_pkg.sv
// constants for the deserializer output-state and self-test block
package dost_pkg;
  localparam logic [7:0] SELFTEST_CONTROL_OFS     = 8'h24;
  localparam logic [7:0] SELFTEST_ERROR_COUNT_OFS = 8'h25;
  localparam int         CTRL_REG_EN_BIT          = 0;
  localparam int         CTRL_CLKSEL_LSB          = 1;
  localparam int         CTRL_PIN_OVERRIDE_BIT    = 3;
  localparam logic [7:0] SELFTEST_CONTROL_RST     = 8'h00;
  localparam logic [7:0] SELFTEST_ERROR_COUNT_RST = 8'h00;
  localparam int         SYNC_STAGES              = 3;
  typedef enum logic [1:0] {
    DOST_CLK_PIXEL,
    DOST_CLK_OSC_FULL,
    DOST_CLK_OSC_HALF,
    DOST_CLK_RESERVED
  } dost_clksel_t;
  typedef enum logic [1:0] {
    DOST_MODE_12B_LF,
    DOST_MODE_12B_HF,
    DOST_MODE_10B
  } dost_mode_t;
endpackage

// ### src/dost_deser_selftest.sv
// output-state control and at-speed self-test checker of the deserializer
`timescale 1ns/1ps
module dost_deser_selftest
  import dost_pkg::*;
#(
  parameter int DATA_W = 12
) (
  input  wire logic                  clk,             // 50 MHz core clock (pixel rate)
  input  wire logic                  arst_n,          // async reset, active low
  input  wire logic                  powerDownBarPin, // high enables the device
  input  wire logic                  outputDriveEnable, // output drive enable setting
  input  wire logic                  outputStateSelect, // output state select setting
  input  wire logic                  cdrLocked,       // recovery lock sequence complete
  input  wire dost_pkg::dost_mode_t  opMode,          // active operating mode
  input  wire logic                  selftestEnablePin, // self-test enable pin
  input  wire logic [1:0]            gpioClkSel,      // general purpose pins 1:0
  input  wire logic                  frameValid,      // one-cycle frame end strobe
  input  wire logic                  frameError,      // frame had payload error
  input  wire logic [DATA_W-1:0]     rxData,          // recovered parallel data
  input  wire logic                  regWrite,        // register write strobe
  input  wire logic [7:0]            regAddr,         // register address
  input  wire logic [7:0]            regWdata,        // register write data
  output logic [7:0]                 regRdata,        // register read data
  output logic                       lockOut,         // lock indicator value
  output logic                       lockOe,          // lock indicator enable
  output logic                       passOut,         // result pin value
  output logic                       passOe,          // result pin enable
  output logic [DATA_W-1:0]          dataOut,         // parallel data value
  output logic                       dataOe,          // data, gpio and clock enable
  output logic                       clkGate,         // pixel clock out allowed
  output logic                       patternRequest,  // back channel start command
  output logic                       selftestActive,  // self-test mode in force
  output dost_pkg::dost_clksel_t     testClkSel,      // chosen test clock source
  output logic [1:0]                 oscRateCode      // 0 pixel,1 full,2 half,3 quarter
);
  import dost_pkg::*;

  if (DATA_W < 10 || DATA_W > 12) begin : g_bad_width
    $error("DATA_W must be 10 to 12");
  end
  if (SYNC_STAGES < 3) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 3");
  end

  logic [7:0]             control_reg;
  logic [7:0]             errCount_reg;
  logic                   testOn_reg;
  logic                   failSeen_reg;
  logic                   testOn_next;
  logic                   passHalf_reg;

  // three stages per pin; a change counts once the last two agree,
  // so a one-cycle glitch never reaches the mode logic
  logic [2:0] pinRaw;
  wire logic [2:0] pinClean;
  assign pinRaw = {gpioClkSel, selftestEnablePin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic [SYNC_STAGES-1:0] sync_reg;
      logic                   clean_reg;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_reg <= '0;
        end else begin
          sync_reg <= {sync_reg[SYNC_STAGES-2:0], pinRaw[gi]};
        end
      end
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          clean_reg <= 1'b0;
        end else if (sync_reg[SYNC_STAGES-1] == sync_reg[SYNC_STAGES-2]) begin
          clean_reg <= sync_reg[SYNC_STAGES-1];
        end
      end
      assign pinClean[gi] = clean_reg;
    end
  endgenerate

  // control register; only bits 3:0 are implemented
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg <= SELFTEST_CONTROL_RST;
    end else if (regWrite && regAddr == SELFTEST_CONTROL_OFS) begin
      control_reg <= {4'h0, regWdata[3:0]};
    end
  end

  // pins rule unless the register takes over
  logic       useReg;
  logic [1:0] csSel;
  always_comb begin
    useReg = control_reg[CTRL_PIN_OVERRIDE_BIT];
    testOn_next = useReg ? control_reg[CTRL_REG_EN_BIT] : pinClean[0];
    csSel = useReg ? control_reg[CTRL_CLKSEL_LSB +: 2] : pinClean[2:1];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      testClkSel <= DOST_CLK_PIXEL;
    end else begin
      testClkSel <= dost_clksel_t'(csSel);
    end
  end

  // rate scales with mode: 10b and 12b hf full, 12b lf 1/2;
  // pin control has fixed rates whatever the mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oscRateCode <= 2'h0;
    end else begin
      case (csSel)
        2'h1: begin
          if (!useReg) begin
            oscRateCode <= 2'h2;
          end else begin
            case (opMode)
              DOST_MODE_12B_LF: oscRateCode <= 2'h2;
              DOST_MODE_12B_HF: oscRateCode <= 2'h1;
              DOST_MODE_10B:    oscRateCode <= 2'h1;
              default:          oscRateCode <= 2'h1;
            endcase
          end
        end
        2'h2: begin
          if (!useReg) begin
            oscRateCode <= 2'h3;
          end else begin
            case (opMode)
              DOST_MODE_12B_LF: oscRateCode <= 2'h3;
              DOST_MODE_12B_HF: oscRateCode <= 2'h2;
              DOST_MODE_10B:    oscRateCode <= 2'h2;
              default:          oscRateCode <= 2'h2;
            endcase
          end
        end
        default: begin
          oscRateCode <= 2'h0; // reserved code falls back to pixel clock
        end
      endcase
    end
  end

  logic checking;
  assign checking = testOn_reg && cdrLocked && powerDownBarPin;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      testOn_reg <= 1'b0;
    end else begin
      testOn_reg <= testOn_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      patternRequest <= 1'b0;
    end else begin
      patternRequest <= testOn_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selftestActive <= 1'b0;
    end else begin
      selftestActive <= testOn_next;
    end
  end

  // count clears on session start; saturates rather than wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      errCount_reg <= SELFTEST_ERROR_COUNT_RST;
    end else if (testOn_next && !testOn_reg) begin
      errCount_reg <= SELFTEST_ERROR_COUNT_RST;
    end else if (checking && frameValid && frameError) begin
      if (errCount_reg != 8'hff) begin
        errCount_reg <= errCount_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      failSeen_reg <= 1'b0;
    end else if (testOn_next && !testOn_reg) begin
      failSeen_reg <= 1'b0;
    end else if (checking && frameValid && frameError) begin
      failSeen_reg <= 1'b1;
    end
  end

  // one core cycle stands for a full pixel period of the result pin,
  // so each errored frame strobe yields its own low cycle
  logic passValue;
  always_comb begin
    if (testOn_reg && !testOn_next) begin
      // the closing cycle must show the verdict, even while still checking
      passValue = !failSeen_reg && !(checking && frameValid && frameError);
    end else if (checking) begin
      passValue = !(frameValid && frameError);
    end else begin
      passValue = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      passHalf_reg <= 1'b0;
    end else if (!powerDownBarPin) begin
      passHalf_reg <= 1'b0;
    end else if (outputDriveEnable && !cdrLocked && outputStateSelect) begin
      passHalf_reg <= passHalf_reg;
    end else begin
      passHalf_reg <= passValue;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        SELFTEST_CONTROL_OFS:     regRdata <= control_reg;
        SELFTEST_ERROR_COUNT_OFS: regRdata <= errCount_reg;
        default:                  regRdata <= 8'h00;
      endcase
    end
  end

  // lock indicator reports status whenever powered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockOut <= 1'b0;
      lockOe  <= 1'b0;
    end else begin
      lockOut <= powerDownBarPin && cdrLocked;
      lockOe  <= powerDownBarPin;
    end
  end

  // result pin; previous state kept while the link is down with drive enable and state select both high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      passOut <= 1'b0;
      passOe  <= 1'b0;
    end else begin
      case ({powerDownBarPin, outputDriveEnable, outputStateSelect})
        3'h4: begin
          passOut <= 1'b0;
          passOe  <= 1'b1;
        end
        3'h5: begin
          passOut <= 1'b0;
          passOe  <= 1'b0;
        end
        3'h6: begin
          passOut <= 1'b0;
          passOe  <= 1'b1;
        end
        3'h7: begin
          passOut <= cdrLocked ? passValue : passHalf_reg;
          passOe  <= 1'b1;
        end
        default: begin
          passOut <= 1'b0;
          passOe  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut <= '0;
      dataOe  <= 1'b0;
    end else begin
      case ({powerDownBarPin, outputDriveEnable, outputStateSelect})
        3'h4: begin
          dataOut <= '0;
          dataOe  <= 1'b1;
        end
        3'h5: begin
          dataOut <= '0;
          dataOe  <= 1'b0;
        end
        3'h6: begin
          dataOut <= '0;
          dataOe  <= 1'b1;
        end
        3'h7: begin
          dataOut <= cdrLocked ? rxData : '0;
          dataOe  <= 1'b1;
        end
        default: begin
          dataOut <= '0;
          dataOe  <= 1'b0;
        end
      endcase
    end
  end

  // clock leaves only with valid data behind it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clkGate <= 1'b0;
    end else begin
      clkGate <= powerDownBarPin && outputDriveEnable && outputStateSelect && cdrLocked;
    end
  end

endmodule

// ### testbench/dost_deser_selftest_props.sv
// assertions on output states and error pulses of the self-test block
`timescale 1ns/1ps
module dost_deser_selftest_props #(parameter int DATA_W = 12) (
  input wire logic              clk,               // clock
  input wire logic              arst_n,            // reset
  input wire logic              powerDownBarPin,   // power
  input wire logic              outputDriveEnable, // drive
  input wire logic              outputStateSelect, // state
  input wire logic              cdrLocked,         // lock in
  input wire logic              frameValid,        // frame
  input wire logic              frameError,        // bad frame
  input wire logic              selftestActive,    // mode
  input wire logic              patternRequest,    // request
  input wire logic [DATA_W-1:0] rxData,            // data in
  input wire logic [DATA_W-1:0] dataOut,           // data pin
  input wire logic              dataOe,            // data en
  input wire logic              lockOut,           // lock pin
  input wire logic              lockOe,            // lock en
  input wire logic              passOut,           // result pin
  input wire logic              passOe             // result en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence outOk;
    powerDownBarPin && outputDriveEnable && outputStateSelect && cdrLocked;
  endsequence
  sequence errFrame;
    selftestActive && frameValid && frameError;
  endsequence
  a_pdown_tristate: assert property (!powerDownBarPin |=> !lockOe && !passOe && !dataOe)
    else $error("outputs driven in power down");
  a_lock_pending: assert property (!cdrLocked |=> !lockOut)
    else $error("lock shown before lock");
  a_lock_shown: assert property (powerDownBarPin && cdrLocked |=> lockOe && lockOut)
    else $error("lock not shown");
  a_hold_low: assert property (powerDownBarPin && !outputDriveEnable && !outputStateSelect |=> dataOe && dataOut == '0)
    else $error("data not driven low");
  a_hold_z: assert property (powerDownBarPin && !outputDriveEnable && outputStateSelect |=> !dataOe && !passOe)
    else $error("data not tristated");
  a_data_valid: assert property (outOk |=> dataOe && dataOut == $past(rxData))
    else $error("data not passed through");
  a_err_pulse: assert property (errFrame ##0 outOk |=> !passOut)
    else $error("no low pulse for errored frame");
  a_req_mode: assert property (patternRequest == selftestActive)
    else $error("pattern request out of step with mode");
  a_idle_low: assert property (!selftestActive && $past(!selftestActive) && outOk |=> !passOut)
    else $error("result pin high outside self-test");
endmodule
bind dost_deser_selftest dost_deser_selftest_props #(.DATA_W(DATA_W)) dost_deser_selftest_props_i (.*);

// ### testbench/dost_far_serializer.sv
// far-end serializer model: lock and test-pattern frames
`timescale 1ns/1ps
module dost_far_serializer #(parameter int DATA_W = 12) (
  input  wire logic         clk,            // core clock
  input  wire logic         arst_n,         // async reset
  input  wire logic         patternRequest, // back channel start
  input  wire logic         burst,          // frames every cycle
  input  wire logic         errMask,        // corrupt frames
  output logic              cdrLocked,      // lock reached
  output logic              frameValid,     // frame end strobe
  output logic              frameError,     // payload bad
  output logic [DATA_W-1:0] rxData          // recovered data
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 4'h0;
      cdrLocked <= 1'b0;
      frameValid <= 1'b0;
      frameError <= 1'b0;
      rxData <= '0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      cdrLocked <= cdrLocked | (cnt_reg == 4'h7);
      frameValid <= patternRequest && (burst || cnt_reg[1:0] == 2'h3);
      frameError <= patternRequest && errMask;
      rxData <= ~rxData ^ DATA_W'(cnt_reg); // changes every cycle
    end
  end
endmodule

// ### testbench/tb.sv
// self-checking bench for the output-state and self-test block
`timescale 1ns/1ps
module tb;
  import dost_pkg::*;
  localparam int DATA_W = 12;
  logic clk = 1'b0, arst_n = 1'b0, powerDownBarPin = 1'b0, outputDriveEnable = 1'b0, outputStateSelect = 1'b0;
  logic selftestEnablePin = 1'b0, regWrite = 1'b0, burst = 1'b0, errMask = 1'b0, frameValid, frameError;
  logic cdrLocked, lockOut, lockOe, passOut, passOe, dataOe, clkGate, patternRequest, selftestActive;
  logic [1:0] gpioClkSel = 2'h0, oscRateCode;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd;
  logic [DATA_W-1:0] rxData, dataOut;
  dost_mode_t opMode = DOST_MODE_12B_LF;
  dost_clksel_t testClkSel;
  int n_mismatch = 0, cmp_count = 0, lows;
  always #10 clk = ~clk; // bench supplies the pixel clock
  dost_deser_selftest #(.DATA_W(DATA_W)) dost_deser_selftest_i (.*);
  dost_far_serializer #(.DATA_W(DATA_W)) dost_far_serializer_i (.*);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic waitMode(input logic exp);
    int i;
    for (i = 0; i < 20 && selftestActive !== exp; i++) @(negedge clk);
    check("selftestActive", 8'(selftestActive), 8'(exp));
    if (i == 20) summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    @(negedge clk);
  endtask
  task automatic rdReg(input logic [7:0] a);
    regAddr = a;
    @(negedge clk);
    rd = regRdata;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    rdReg(SELFTEST_CONTROL_OFS);
    check("control", rd, SELFTEST_CONTROL_RST);
    rdReg(SELFTEST_ERROR_COUNT_OFS);
    check("count", rd, SELFTEST_ERROR_COUNT_RST);
    rdReg(8'h30);
    check("unmapped", rd, 8'h00);
    for (int k = 0; k < 8; k++) begin
      {powerDownBarPin, outputDriveEnable, outputStateSelect} = 3'(k);
      repeat (2) @(negedge clk);
      check("dataOe", 8'(dataOe), 8'(k[2] && k[1:0] != 2'b01));
      check("passOe", 8'(passOe), 8'(k[2] && k[1:0] != 2'b01));
      check("lockOe", 8'(lockOe), 8'(k[2]));
      check("clkGate", 8'(clkGate), 8'(k == 7));
    end
    check("lockOut", 8'(lockOut), 8'h01);
    $display("output state test done");
    wr(SELFTEST_CONTROL_OFS, 8'h09);
    waitMode(1'b1);
    check("request", 8'(patternRequest), 8'h01);
    repeat (2) @(negedge clk);
    check("passHigh", 8'(passOut), 8'h01);
    lows = 0;
    fork
      repeat (30) begin
        @(negedge clk);
        lows += int'(passOut === 1'b0);
      end
      begin
        burst = 1'b1;
        errMask = 1'b1;
        repeat (2) @(negedge clk);
        burst = 1'b0;
        repeat (4) @(negedge clk);
        errMask = 1'b0;
      end
    join
    check("lowCycles", 8'(lows), 8'h03);
    wr(SELFTEST_CONTROL_OFS, 8'h08);
    check("failResult", 8'(passOut), 8'h00);
    waitMode(1'b0);
    rdReg(SELFTEST_ERROR_COUNT_OFS);
    check("countHeld", rd, 8'h03);
    wr(SELFTEST_CONTROL_OFS, 8'h09);
    rdReg(SELFTEST_ERROR_COUNT_OFS);
    check("countCleared", rd, 8'h00);
    $display("error count test done");
    for (int s = 0; s < 3; s++) begin
      opMode = dost_mode_t'(s);
      wr(SELFTEST_CONTROL_OFS, 8'(9 + 2 * s));
      @(negedge clk);
      check("clkSel", 8'(testClkSel), 8'(s));
      check("rate", 8'(oscRateCode), 8'(s));
    end
    wr(SELFTEST_CONTROL_OFS, 8'h00);
    check("passResult", 8'(passOut), 8'h01);
    @(negedge clk);
    check("resultGone", 8'(passOut), 8'h00);
    waitMode(1'b0);
    selftestEnablePin = 1'b1;
    @(negedge clk);
    selftestEnablePin = 1'b0;
    repeat (8) @(negedge clk);
    check("glitch", 8'(selftestActive), 8'h00);
    gpioClkSel = 2'h1;
    selftestEnablePin = 1'b1;
    waitMode(1'b1);
    @(negedge clk);
    check("pinSel", 8'(testClkSel), 8'h01);
    check("pinRate", 8'(oscRateCode), 8'h02);
    selftestEnablePin = 1'b0;
    waitMode(1'b0);
    $display("clock select and pin test done");
    summarize();
  end
endmodule
